// file: rtl/comm_fault_pkg.sv
// Package: register map, field positions and timing for the comm fault block
package comm_fault_pkg;
  // Printed offsets are register indices; byte address is four times these
  localparam logic [11:0] IDX_PORT_FLAGS = 12'h531;
  localparam logic [11:0] IDX_TONE_FLAGS = 12'h532;
  localparam logic [11:0] IDX_CTRL = 12'h540;
  localparam logic [11:0] IDX_DEBUG = 12'h541;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // Port flag positions
  localparam int B_LOW_TR = 7;
  localparam int B_LOW_RR = 6;
  localparam int B_LOW_RC = 5;
  localparam int B_LOW_BIT = 4;
  localparam int B_HIGH_TR = 3;
  localparam int B_HIGH_RR = 2;
  localparam int B_HIGH_RC = 1;
  localparam int B_HIGH_BIT = 0;
  // Tone and heartbeat flag positions
  localparam int B_FWD = 3;
  localparam int B_TONE = 2;
  localparam int B_HB_MISS = 1;
  localparam int B_HEARTBEAT_TOO_FAST = 0;
  // Control register fields (clear bits self-clear)
  localparam int C_CLR_PORT = 0;
  localparam int C_CLR_HB = 1;
  localparam int C_CLR_TONE = 2;
  localparam int C_CLR_FWD = 3;
  localparam int C_DIR_SEL = 8;
  localparam int C_MSK_PORT = 9;
  localparam int C_MSK_HB = 10;
  localparam int C_MSK_TONE = 11;
  localparam int C_MSK_FWD = 12;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Heartbeat window times in microseconds, clock period in ns
  localparam int CLK_NS = 100;
  localparam int HB_MAX_US = 2000;
  localparam int HB_MIN_US = 100;
  localparam int HB_MAX_CYC = HB_MAX_US * 1000 / CLK_NS;
  localparam int HB_MIN_CYC = (HB_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  // Events reported by one daisy-chain port
  typedef struct packed {
    logic tx_resp_byte_err; // Byte fault while sending a response
    logic rx_resp_byte_err; // Byte fault while receiving a response
    logic rx_cmd_byte_err;  // Byte fault while receiving a command
    logic bit_err;          // Bit error leading to a byte fault
    logic [3:0] cause;      // Fault cause code for debug
    logic tone;             // Fault tone received
    logic heartbeat;        // Heartbeat received
  } port_evt_t;
endpackage

// file: rtl/hb_watch.sv
// Heartbeat watchdog: missing and too-fast heartbeat detection
`timescale 1ns/1ps
`default_nettype none
module hb_watch #(
  parameter int MAX_CYC = 20000,
  parameter int MIN_CYC = 1000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Monitored heartbeat pulse
  input wire logic heartbeat,
  // Restart timing after selection change
  input wire logic restart,
  // One-cycle detections
  output logic miss_pulse,
  output logic fast_pulse
);
  // Refuse windows the 24-bit counter cannot serve
  if (MIN_CYC < 1 || MAX_CYC <= MIN_CYC ||
      MAX_CYC > 16777215) begin : g_bad_window
    $error("hb_watch: bad window");
  end
  logic [23:0] cnt_r, cnt_nxt; // Cycles since last heartbeat
  logic armed_r, armed_nxt;    // Low once a miss is reported
  logic seen_r, seen_nxt;      // A heartbeat arrived since restart
  localparam logic [23:0] MAXV = 24'(MAX_CYC);
  localparam logic [23:0] MINV = 24'(MIN_CYC);
  // Next counter and detections
  always_comb begin
    cnt_nxt = cnt_r;
    armed_nxt = armed_r;
    seen_nxt = seen_r;
    miss_pulse = 1'b0;
    fast_pulse = 1'b0;
    if (restart) begin
      cnt_nxt = '0;
      armed_nxt = 1'b1;
      seen_nxt = 1'b0;
    end else if (heartbeat) begin
      // Too soon after previous one; the first has no predecessor
      fast_pulse = seen_r && (cnt_r < MINV);
      cnt_nxt = '0;
      armed_nxt = 1'b1;
      seen_nxt = 1'b1;
    end else if (armed_r && cnt_r >= MAXV) begin
      // Window expired without a heartbeat
      miss_pulse = 1'b1;
      armed_nxt = 1'b0;
    end else if (armed_r) begin
      cnt_nxt = cnt_r + 24'h000001;
    end
  end
  // Register state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      armed_r <= 1'b1;
      seen_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      armed_r <= armed_nxt;
      seen_r <= seen_nxt;
    end
  end
endmodule
`default_nettype wire

// file: rtl/comm_fault_regs.sv
// Daisy-chain communication fault status registers with AXI4-Lite access
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Transmit response byte faults set tx flags
// - Low port response receive fault sets flag
// - Low port command receive fault, debug kept
// - High port response receive fault sets flag
// - High port command receive fault, debug kept
// - Bit errors set per-port bit flags
// - Forwarded chain fault sets forwarded flag
// - Fault tone on watched port sets flag
// - Direction select picks low or high port
// - Missing heartbeat sets missing flag
// - Too frequent heartbeat sets fast flag
// - Fast flag may accompany tone flag
// - Port clear zeroes port flags and debug
// - Chain flag groups clear independently
// - Summary honours per-group masks
module comm_fault_regs #(
  parameter int HB_MAX = comm_fault_pkg::HB_MAX_CYC,
  parameter int HB_MIN = comm_fault_pkg::HB_MIN_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port event inputs
  input wire comm_fault_pkg::port_evt_t low_evt,
  input wire comm_fault_pkg::port_evt_t high_evt,
  input wire logic fwd_fault,
  // Communication summary
  output logic comm_summary
);
  import comm_fault_pkg::*;
  // Control field positions inside the stored config word
  localparam int F_DIR = C_DIR_SEL - C_DIR_SEL;
  localparam int F_MSK_PORT = C_MSK_PORT - C_DIR_SEL;
  localparam int F_MSK_HB = C_MSK_HB - C_DIR_SEL;
  localparam int F_MSK_TONE = C_MSK_TONE - C_DIR_SEL;
  localparam int F_MSK_FWD = C_MSK_FWD - C_DIR_SEL;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] port_r, port_nxt;   // Port fault flags
  logic [3:0] tone_r, tone_nxt;   // Tone and heartbeat flags
  logic [7:0] dbg_r, dbg_nxt;     // Command receive cause, low/high nibbles
  logic [4:0] cfg_r, cfg_nxt;     // Direction select and masks
  logic aw_r, aw_nxt;             // Write address held
  logic w_r, w_nxt;               // Write data held
  logic [13:0] awa_r, awa_nxt;    // Held write address
  logic [31:0] wd_r, wd_nxt;      // Held write data
  logic [3:0] ws_r, ws_nxt;       // Held strobes
  logic bv_r, bv_nxt;             // Write response pending
  logic [1:0] br_r, br_nxt;       // Write response code
  logic rv_r, rv_nxt;             // Read data pending
  logic [31:0] rd_r, rd_nxt;      // Read data
  logic [1:0] rr_r, rr_nxt;       // Read response code
  logic dir_q_r;                  // Previous direction select

  ////////////////////////////////////////////////////////////////////////////
  // Heartbeat watch on the selected port
  logic dir_sel;
  logic hb_sel, tone_sel, hb_miss, heartbeat_too_fast;
  assign dir_sel = cfg_r[F_DIR];
  assign hb_sel = dir_sel ? high_evt.heartbeat : low_evt.heartbeat;
  assign tone_sel = dir_sel ? high_evt.tone : low_evt.tone;

  hb_watch #(
    .MAX_CYC(HB_MAX),
    .MIN_CYC(HB_MIN)
  ) u_hb (
    .aclk(aclk),
    .aresetn(aresetn),
    // A tone also counts as an arrival, so it can flag too fast
    .heartbeat(hb_sel | tone_sel),
    // Selecting the other port restarts the window
    .restart(dir_sel != dir_q_r),
    .miss_pulse(hb_miss),
    .fast_pulse(heartbeat_too_fast)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic wr_go, rd_go;
  logic [11:0] widx, ridx;
  logic [7:0] wbyte0, wbyte1;
  // Write executes once both halves are held and no answer waits
  assign wr_go = aw_r && w_r && !bv_r;
  // A read is taken only while no read data is waiting
  assign rd_go = s_axi_arvalid && !rv_r;
  assign widx = awa_r[13:2];
  assign ridx = s_axi_araddr[13:2];
  // Lanes without a strobe leave their fields as they were
  assign wbyte0 = ws_r[0] ? wd_r[7:0] : 8'h00;
  assign wbyte1 = ws_r[1] ? wd_r[15:8] : {3'b000, cfg_r};
  // Ready outputs follow the held flags directly
  assign s_axi_awready = !aw_r;
  assign s_axi_wready = !w_r;
  assign s_axi_arready = !rv_r;
  // Response channels come straight from registers
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = br_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rdata = rd_r;
  assign s_axi_rresp = rr_r;

  // Clear strobes from a control write, one cycle
  logic wr_ctrl, clr_port, clr_hb, clr_tone, clr_fwd;
  assign wr_ctrl = wr_go && (widx == IDX_CTRL);
  assign clr_port = wr_ctrl && wbyte0[C_CLR_PORT];
  assign clr_hb = wr_ctrl && wbyte0[C_CLR_HB];
  assign clr_tone = wr_ctrl && wbyte0[C_CLR_TONE];
  assign clr_fwd = wr_ctrl && wbyte0[C_CLR_FWD];

  ////////////////////////////////////////////////////////////////////////////
  // Next flag values: clear first, then events set, so set wins
  // Event bits placed at their flag positions
  logic [7:0] port_set;
  logic [3:0] tone_set;
  always_comb begin
    port_set = 8'h00;
    port_set[B_LOW_TR] = low_evt.tx_resp_byte_err;
    port_set[B_HIGH_TR] = high_evt.tx_resp_byte_err;
    port_set[B_LOW_RR] = low_evt.rx_resp_byte_err;
    port_set[B_LOW_RC] = low_evt.rx_cmd_byte_err;
    port_set[B_HIGH_RR] = high_evt.rx_resp_byte_err;
    port_set[B_HIGH_RC] = high_evt.rx_cmd_byte_err;
    port_set[B_LOW_BIT] = low_evt.bit_err;
    port_set[B_HIGH_BIT] = high_evt.bit_err;
    tone_set = 4'h0;
    tone_set[B_FWD] = fwd_fault;
    tone_set[B_TONE] = tone_sel;
    tone_set[B_HB_MISS] = hb_miss;
    tone_set[B_HEARTBEAT_TOO_FAST] = heartbeat_too_fast;
    port_nxt = (clr_port ? FLAGS_RESET : port_r) | port_set;
    dbg_nxt = clr_port ? FLAGS_RESET : dbg_r;
    if (low_evt.rx_cmd_byte_err) begin
      dbg_nxt[3:0] = low_evt.cause;
    end
    if (high_evt.rx_cmd_byte_err) begin
      dbg_nxt[7:4] = high_evt.cause;
    end
    tone_nxt = tone_r;
    // Each group clears on its own strobe
    if (clr_fwd) begin
      tone_nxt[B_FWD] = 1'b0;
    end
    if (clr_tone) begin
      tone_nxt[B_TONE] = 1'b0;
    end
    if (clr_hb) begin
      tone_nxt[B_HB_MISS] = 1'b0;
      tone_nxt[B_HEARTBEAT_TOO_FAST] = 1'b0;
    end
    tone_nxt = tone_nxt | tone_set;
  end

  // Summary gated per group by masks
  // Each group counts only while its own mask is clear
  always_comb begin
    comm_summary = (!cfg_r[F_MSK_PORT] && (|port_r)) ||
      (!cfg_r[F_MSK_HB] && (tone_r[B_HB_MISS] || tone_r[B_HEARTBEAT_TOO_FAST])) ||
      (!cfg_r[F_MSK_TONE] && tone_r[B_TONE]) ||
      (!cfg_r[F_MSK_FWD] && tone_r[B_FWD]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next bus state
  always_comb begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    bv_nxt = bv_r;
    br_nxt = br_r;
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    cfg_nxt = cfg_r;
    // Accept address and data in either order
    if (s_axi_awvalid && !aw_r) begin
      aw_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_r) begin
      w_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    // Perform write; status registers ignore writes but answer OKAY
    if (wr_go) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      bv_nxt = 1'b1;
      case (widx)
        IDX_CTRL: begin
          br_nxt = RESP_OKAY;
          cfg_nxt = wbyte1[4:0];
        end
        IDX_PORT_FLAGS, IDX_TONE_FLAGS, IDX_DEBUG: begin
          br_nxt = RESP_OKAY;
        end
        default: begin
          br_nxt = RESP_SLVERR;
        end
      endcase
    end else if (bv_r && s_axi_bready) begin
      // Master has taken the write response
      bv_nxt = 1'b0;
    end
    // Read answer one cycle after acceptance
    if (rd_go) begin
      rv_nxt = 1'b1;
      rr_nxt = RESP_OKAY;
      case (ridx)
        IDX_PORT_FLAGS: begin
          rd_nxt = {24'h000000, port_r};
        end
        IDX_TONE_FLAGS: begin
          rd_nxt = {28'h0000000, tone_r};
        end
        IDX_CTRL: begin
          rd_nxt = {19'h00000, cfg_r, 8'h00};
        end
        IDX_DEBUG: begin
          rd_nxt = {24'h000000, dbg_r};
        end
        default: begin
          // Unmapped index: error with zero data
          rd_nxt = 32'h00000000;
          rr_nxt = RESP_SLVERR;
        end
      endcase
    end else if (rv_r && s_axi_rready) begin
      // Master has taken the read data
      rv_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Flags, config and bus state all start cleared
      port_r <= FLAGS_RESET;
      tone_r <= 4'h0;
      dbg_r <= FLAGS_RESET;
      cfg_r <= 5'h00;
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awa_r <= 14'h0000;
      wd_r <= 32'h00000000;
      ws_r <= 4'h0;
      bv_r <= 1'b0;
      br_r <= RESP_OKAY;
      rv_r <= 1'b0;
      rd_r <= 32'h00000000;
      rr_r <= RESP_OKAY;
      dir_q_r <= 1'b0;
    end else begin
      port_r <= port_nxt;
      tone_r <= tone_nxt;
      dbg_r <= dbg_nxt;
      cfg_r <= cfg_nxt;
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      bv_r <= bv_nxt;
      br_r <= br_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
      rr_r <= rr_nxt;
      dir_q_r <= dir_sel;
    end
  end
endmodule
`default_nettype wire

// file: sim/comm_fault_monitor.sv
// Checker for bus handshakes and summary of the fault registers
`timescale 1ns/1ps
`default_nettype none
module comm_fault_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Summary
  input wire logic comm_summary
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles on");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  b_resp_a: assert property (s_axi_bvalid |-> s_axi_bresp[0] == 1'b0)
    else $error("write response code illegal");
  sum_fall_a: assert property ($fell(comm_summary) |-> $rose(s_axi_bvalid))
    else $error("summary fell without a write");
endmodule
bind comm_fault_regs comm_fault_monitor mon (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .comm_summary(comm_summary)
);
`default_nettype wire

// file: sim/chain_neighbour.sv
// Neighbour device model: heartbeats and fault events on both ports
`timescale 1ns/1ps
`default_nettype none
module chain_neighbour (
  // Clock
  input wire logic aclk,
  // Heartbeat period in cycles, zero stops it; side select
  input wire logic [7:0] hb_per,
  input wire logic hb_hi,
  // Event requests from the bench
  input wire comm_fault_pkg::port_evt_t lo_req,
  input wire comm_fault_pkg::port_evt_t hi_req,
  // Events toward the device
  output var comm_fault_pkg::port_evt_t low_evt = '0,
  output var comm_fault_pkg::port_evt_t high_evt = '0
);
  import comm_fault_pkg::*;
  int cnt = 0; // Cycles since the last heartbeat
  // Pass requests on a cycle later, add heartbeats on the chosen port
  always @(posedge aclk) begin
    cnt <= (cnt + 1 >= hb_per) ? 0 : cnt + 1;
    low_evt <= lo_req;
    high_evt <= hi_req;
    if (hb_per != 0 && cnt == 0) begin
      if (hb_hi) high_evt.heartbeat <= 1'b1;
      else low_evt.heartbeat <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: sim/test_daisy_chain_comm_fault_status.sv
// Self-checking bench for the chain fault status registers
`timescale 1ns/1ps
`default_nettype none
module test_daisy_chain_comm_fault_status;
  import comm_fault_pkg::*;
  localparam int HBMX = 40; // Shortened heartbeat window
  localparam logic [13:0] A_P = {IDX_PORT_FLAGS, 2'b00};
  localparam logic [13:0] A_T = {IDX_TONE_FLAGS, 2'b00};
  localparam logic [13:0] A_C = {IDX_CTRL, 2'b00};
  localparam logic [13:0] A_D = {IDX_DEBUG, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, fwd_fault = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, comm_summary;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  port_evt_t low_evt, high_evt, lo_req = '0, hi_req = '0;
  logic [7:0] hb_per = 8'h0A; // Heartbeat every ten cycles
  logic hb_hi = 1'b0;
  logic [3:0] c;
  logic [7:0] m_dbg = 8'h00; // Model of the debug causes
  int n_mismatch = 0, compares = 0, seed = 60, m_port = 0;
  comm_fault_regs #(.HB_MAX(HBMX), .HB_MIN(5)) uut (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .low_evt(low_evt),
    .high_evt(high_evt),
    .fwd_fault(fwd_fault),
    .comm_summary(comm_summary)
  );
  chain_neighbour nb (
    .aclk(aclk),
    .hb_per(hb_per),
    .hb_hi(hb_hi),
    .lo_req(lo_req),
    .hi_req(hi_req),
    .low_evt(low_evt),
    .high_evt(high_evt)
  );
  // Clock
  initial forever #50 aclk = ~aclk;
  task automatic chk(input string s, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // Summary is combinational: look at it mid-cycle, once settled
  task automatic chk_sum(input logic e);
    @(negedge aclk);
    chk("summary", {31'h0, e}, {31'h0, comm_summary});
  endtask
  // One bus transfer, read when rd is set
  task automatic xfer(input bit rd, input logic [13:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
    bit ka, kw, kd, kb, kr;
    @(posedge aclk);
    if (rd) begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end else begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    do begin
      @(negedge aclk);
      ka = s_axi_arvalid & s_axi_arready;
      kw = s_axi_awvalid & s_axi_awready;
      kd = s_axi_wvalid & s_axi_wready;
      kb = s_axi_bvalid & s_axi_bready;
      kr = s_axi_rvalid & s_axi_rready;
      q = s_axi_rdata;
      r = rd ? s_axi_rresp : s_axi_bresp;
      @(posedge aclk);
      if (ka) s_axi_arvalid <= 1'b0;
      if (kw) s_axi_awvalid <= 1'b0;
      if (kd) s_axi_wvalid <= 1'b0;
      if (kb) s_axi_bready <= 1'b0;
      if (kr) s_axi_rready <= 1'b0;
    end while (!(kb | kr));
  endtask
  // Read and compare the bits under mask m
  task automatic rdc(input logic [13:0] a, input logic [31:0] e, m,
    input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    xfer(1'b1, a, '0, q, r);
    chk("rdata", e & m, q & m);
    chk("rresp", er, r);
  endtask
  task automatic wrc(input logic [13:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0] r;
    xfer(1'b0, a, d, q, r);
    chk("bresp", RESP_OKAY, r);
  endtask
  // One-cycle event on a port
  task automatic ev(input logic [9:0] v, input bit hi);
    @(posedge aclk);
    if (hi) hi_req <= v;
    else lo_req <= v;
    @(posedge aclk);
    lo_req <= '0;
    hi_req <= '0;
  endtask
  task automatic complete_run;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(A_T, 0, '1, RESP_OKAY);
    wrc(A_P, 32'hFF);
    rdc(A_P, 0, '1, RESP_OKAY);
    rdc(14'h0000, 0, '1, RESP_SLVERR);
    for (int b = 7; b >= 0; b--) begin
      c = 4'($random(seed));
      ev(10'd1 << (b > 3 ? b + 2 : b + 6) | {4'h0, c, 2'b00}, b < 4);
      m_port |= 1 << b;
      if (b == 5) m_dbg[3:0] = c;
      if (b == 1) m_dbg[7:4] = c;
      rdc(A_P, m_port, '1, RESP_OKAY);
      chk_sum(m_port != 0);
    end
    rdc(A_T, 0, '1, RESP_OKAY);
    rdc(A_D, m_dbg, '1, RESP_OKAY);
    wrc(A_C, 32'h200);
    chk_sum(1'b0);
    wrc(A_C, 32'h201);
    rdc(A_P, 0, '1, RESP_OKAY);
    rdc(A_D, 0, '1, RESP_OKAY);
    rdc(A_C, 32'h200, '1, RESP_OKAY);
    @(posedge aclk) fwd_fault <= 1'b1;
    @(posedge aclk) fwd_fault <= 1'b0;
    rdc(A_T, 8, 'hE, RESP_OKAY);
    chk_sum(1'b1);
    ev(10'd2, 1'b1);
    rdc(A_T, 8, 'hE, RESP_OKAY);
    ev(10'd2, 1'b0);
    rdc(A_T, 'hC, 'hE, RESP_OKAY);
    wrc(A_C, 32'h208);
    rdc(A_T, 4, 'hE, RESP_OKAY);
    wrc(A_C, 32'h204);
    wrc(A_C, 32'h202);
    rdc(A_T, 0, '1, RESP_OKAY);
    hb_per <= 8'h00;
    repeat (HBMX + 20) @(posedge aclk);
    rdc(A_T, 2, '1, RESP_OKAY);
    hb_per <= 8'h02;
    wrc(A_C, 32'h202);
    repeat (20) @(posedge aclk);
    rdc(A_T, 1, '1, RESP_OKAY);
    hb_per <= 8'h0A;
    repeat (20) @(posedge aclk);
    wrc(A_C, 32'h302);
    repeat (HBMX + 20) @(posedge aclk);
    rdc(A_T, 2, '1, RESP_OKAY);
    hb_hi <= 1'b1;
    wrc(A_C, 32'h302);
    repeat (HBMX + 20) @(posedge aclk);
    rdc(A_T, 0, '1, RESP_OKAY);
    complete_run();
  end
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
